// ### src/selftest_result_flags.sv
// self-test result flags with serial register access
`timescale 1ns/1ps
module selftest_result_flags (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // serial pins from the host (asynchronous to mclk)
   input  wire logic       sclk,
   input  wire logic       cs_b,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe_b,
   // self-test failure events, one-cycle pulses on mclk
   input  wire logic       selftest_overall_fail,
   input  wire logic       thermal_trip_check_fail,
   input  wire logic       prereg_overvolt_check_fail,
   input  wire logic       prereg_undervolt_check_fail,
   input  wire logic       mcu_rail_overvolt_check_fail,
   input  wire logic       mcu_rail_undervolt_check_fail,
   input  wire logic       general_rail_overvolt_check_fail,
   input  wire logic       general_rail_undervolt_check_fail,
   input  wire logic       sensor_one_overvolt_check_fail,
   input  wire logic       sensor_one_undervolt_check_fail,
   input  wire logic       sensor_two_overvolt_check_fail,
   input  wire logic       sensor_two_undervolt_check_fail,
   // flag contents for the rest of the device
   output logic [7:0]      result_main,
   output logic [3:0]      result_sensor,
   // pulse when a frame is rejected for bad parity
   output logic            frame_err
);

   //*************************************************************
   // state
   //*************************************************************
   typedef struct packed {
      logic [1:0]  sclk_sync;   // sclk synchroniser
      logic [1:0]  cs_sync;     // chip select synchroniser
      logic [1:0]  mosi_sync;   // data synchroniser
      logic        sclk_last;   // previous synchronised sclk
      logic        cs_last;     // previous synchronised select
      logic [4:0]  bit_cnt;     // bits received in frame
      logic [15:0] shift_in;    // received frame
      logic [15:0] shift_out;   // answer frame
      logic        miso_q;      // registered miso level
      logic [7:0]  main_q;      // main result register
      logic [3:0]  sensor_q;    // sensor result register
      logic        err_q;       // parity error pulse
   } state_s;

   state_s st_ff;      // registered state
   state_s nxt_st;     // next state

   // check bit that makes the ones of a whole frame odd in total
   function automatic logic parity_of(input logic [14:0] v);
      return ~(^v);
   endfunction

   // address field of a frame, used by the write and answer paths
   function automatic logic [4:0] addr_of(input logic [15:0] f);
      return f[selftest_pkg::ADDR_MSB:selftest_pkg::ADDR_LSB];
   endfunction

   // register read decode, used for the answer frame
   function automatic logic [7:0] read_mux(input logic [4:0] a,
                                           input logic [7:0] m,
                                           input logic [3:0] s);
      if (a == selftest_pkg::ADDR_RESULT_MAIN) begin
         return m;
      end else if (a == selftest_pkg::ADDR_RESULT_SENSOR) begin
         return {4'h0, s};   // upper bits read zero
      end else begin
         return 8'h00;
      end
   endfunction

   // incoming event vectors
   logic [7:0] main_set;     // main register set pulses
   logic [3:0] sensor_set;   // sensor register set pulses

   assign main_set = {selftest_overall_fail,
                      thermal_trip_check_fail,
                      prereg_overvolt_check_fail,
                      prereg_undervolt_check_fail,
                      mcu_rail_overvolt_check_fail,
                      mcu_rail_undervolt_check_fail,
                      general_rail_overvolt_check_fail,
                      general_rail_undervolt_check_fail};
   assign sensor_set = {sensor_one_overvolt_check_fail,
                        sensor_one_undervolt_check_fail,
                        sensor_two_overvolt_check_fail,
                        sensor_two_undervolt_check_fail};

   //*************************************************************
   // next-state logic
   //*************************************************************
   logic        sclk_rise;   // rising edge of synchronised sclk
   logic        sclk_fall;   // falling edge of synchronised sclk
   logic        frame_open;  // select asserted (low)
   logic        frame_done;  // sixteenth bit just sampled
   logic [15:0] full_frame;  // frame including latest bit
   logic        wr_ok;       // valid write frame
   logic [7:0]  main_clr;    // write-one-to-clear masks
   logic [3:0]  sensor_clr;
   logic [7:0]  rd_data;     // data for the answer

   always_comb begin
      nxt_st = st_ff;
      // synchronisers: the first stage may settle late, so nothing
      // but the second stage ever reads it
      nxt_st.sclk_sync = {st_ff.sclk_sync[0], sclk};
      nxt_st.cs_sync   = {st_ff.cs_sync[0], cs_b};
      nxt_st.mosi_sync = {st_ff.mosi_sync[0], mosi};
      nxt_st.sclk_last = st_ff.sclk_sync[1];
      nxt_st.cs_last   = st_ff.cs_sync[1];
      nxt_st.err_q     = 1'b0;

      sclk_rise  = st_ff.sclk_sync[1] & ~st_ff.sclk_last;
      sclk_fall  = ~st_ff.sclk_sync[1] & st_ff.sclk_last;
      frame_open = ~st_ff.cs_sync[1];
      full_frame = {st_ff.shift_in[14:0], st_ff.mosi_sync[1]};
      frame_done = frame_open & sclk_rise &
                   (st_ff.bit_cnt == selftest_pkg::BIT_CNT_LAST);
      // write taken only with good parity, type bit set
      wr_ok = frame_done & full_frame[selftest_pkg::TYPE_POS] &
              (parity_of(full_frame[15:1]) ==
               full_frame[selftest_pkg::PARITY_POS]);
      main_clr   = 8'h00;
      sensor_clr = 4'h0;
      // a one in the data field clears that flag, a zero leaves it
      if (wr_ok) begin
         if (addr_of(full_frame) == selftest_pkg::ADDR_RESULT_MAIN) begin
            main_clr = full_frame[selftest_pkg::DATA_MSB:
                                  selftest_pkg::DATA_LSB];
         end
         if (addr_of(full_frame) == selftest_pkg::ADDR_RESULT_SENSOR) begin
            // only the low four data bits name sensor flags
            sensor_clr = full_frame[selftest_pkg::DATA_LSB + 3:
                                    selftest_pkg::DATA_LSB];
         end
      end
      if (frame_done && (parity_of(full_frame[15:1]) !=
                         full_frame[selftest_pkg::PARITY_POS])) begin
         nxt_st.err_q = 1'b1;
      end

      // flags: a set in the clearing cycle wins
      nxt_st.main_q   = (st_ff.main_q & ~main_clr) | main_set;
      nxt_st.sensor_q = (st_ff.sensor_q & ~sensor_clr) | sensor_set;

      // answer frame, loaded when select falls
      rd_data = 8'h00;
      if (frame_open && st_ff.cs_last) begin
         // a new frame starts: load answer for the last address; the
         // flags are copied here, so an event later in the frame
         // shows up in the answer of the frame after
         rd_data = read_mux(addr_of(st_ff.shift_in), st_ff.main_q,
                            st_ff.sensor_q);
         nxt_st.shift_out = {addr_of(st_ff.shift_in), 1'b0, 1'b0,
                             rd_data,
                             parity_of({addr_of(st_ff.shift_in), 2'b00,
                                        rd_data})};
         nxt_st.miso_q  = st_ff.shift_in[15];
         nxt_st.bit_cnt = 5'h00;
      end else if (frame_open) begin
         // bits past the sixteenth are ignored until select rises: the
         // counter stops and the captured frame stays intact
         if (sclk_rise && (st_ff.bit_cnt <= selftest_pkg::BIT_CNT_LAST)) begin
            nxt_st.shift_in = full_frame;
            nxt_st.bit_cnt  = st_ff.bit_cnt + 5'h01;
         end
         if (sclk_fall) begin
            nxt_st.shift_out = {st_ff.shift_out[14:0], 1'b0};
            nxt_st.miso_q    = st_ff.shift_out[14];
         end
      end
   end

   //*************************************************************
   // state register
   //*************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff          <= '0;
         st_ff.sclk_sync <= 2'h0;
         st_ff.cs_sync   <= 2'h3;
         st_ff.cs_last   <= 1'b1;
         st_ff.main_q    <= selftest_pkg::RESULT_MAIN_RST;
         st_ff.sensor_q  <= selftest_pkg::RESULT_SENSOR_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign miso          = st_ff.miso_q;
   assign miso_oe_b     = st_ff.cs_sync[1];   // drive while selected
   assign result_main   = st_ff.main_q;
   assign result_sensor = st_ff.sensor_q;
   assign frame_err     = st_ff.err_q;

   //*************************************************************
   // assertions
   //*************************************************************
   // first cycle with select low after a gap, answer gets loaded
   sequence s_frame_start;
      frame_open && st_ff.cs_last;
   endsequence

   // the frame before named the sensor register
   sequence s_last_was_sensor;
      addr_of(st_ff.shift_in) == selftest_pkg::ADDR_RESULT_SENSOR;
   endsequence

   // the frame before named neither result register
   sequence s_last_was_other;
      (addr_of(st_ff.shift_in) != selftest_pkg::ADDR_RESULT_MAIN) &&
      (addr_of(st_ff.shift_in) != selftest_pkg::ADDR_RESULT_SENSOR);
   endsequence

   // a good write frame to the main register just ended
   sequence s_main_write;
      wr_ok && (addr_of(full_frame) == selftest_pkg::ADDR_RESULT_MAIN);
   endsequence

   // flags follow their events and survive until written; bad parity raises a one-cycle error pulse
   a_overall_set_wins: assert property (
      @(posedge mclk) disable iff (!rst_b)
      selftest_overall_fail |=> result_main[7])
      else $error("overall flag not set after event");
   a_thermal_sticky: assert property (
      @(posedge mclk) disable iff (!rst_b)
      result_main[6] && !wr_ok |=> result_main[6])
      else $error("thermal flag lost without write");
   a_prereg_ov_flag: assert property (
      @(posedge mclk) disable iff (!rst_b)
      prereg_overvolt_check_fail |=> result_main[5])
      else $error("prereg overvolt flag missing");
   a_prereg_uv_flag: assert property (
      @(posedge mclk) disable iff (!rst_b)
      prereg_undervolt_check_fail |=> result_main[4])
      else $error("prereg undervolt flag missing");
   a_mcu_rail_flags: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !$past(mcu_rail_overvolt_check_fail) && !$past(result_main[3])
      |-> !result_main[3])
      else $error("controller rail flag set without cause");
   a_mcu_uv_flag: assert property (
      @(posedge mclk) disable iff (!rst_b)
      mcu_rail_undervolt_check_fail
      |=> result_main[selftest_pkg::BIT_MCU_UV])
      else $error("controller rail undervolt flag missing");
   a_general_ov_flag: assert property (
      @(posedge mclk) disable iff (!rst_b)
      general_rail_overvolt_check_fail |=> result_main[1])
      else $error("general rail overvolt flag missing");
   a_general_uv_flag: assert property (
      @(posedge mclk) disable iff (!rst_b)
      general_rail_undervolt_check_fail |=> result_main[0])
      else $error("general rail undervolt flag missing");
   a_sensor_clear: assert property (
      @(posedge mclk) disable iff (!rst_b)
      sensor_clr[3] && !sensor_one_overvolt_check_fail
      |=> !result_sensor[3])
      else $error("sensor one overvolt flag not cleared");
   a_sensor_uv_flags: assert property (
      @(posedge mclk) disable iff (!rst_b)
      sensor_one_undervolt_check_fail |=> result_sensor[2])
      else $error("sensor one undervolt flag missing");
   a_sensor_two_ov: assert property (
      @(posedge mclk) disable iff (!rst_b)
      sensor_two_overvolt_check_fail |=> result_sensor[1])
      else $error("sensor two overvolt flag missing");
   a_sensor_two_uv: assert property (
      @(posedge mclk) disable iff (!rst_b)
      sensor_two_undervolt_check_fail |=> result_sensor[0])
      else $error("sensor two undervolt flag missing");
   a_bad_parity_err: assert property (
      @(posedge mclk) disable iff (!rst_b)
      frame_done && !wr_ok && full_frame[10] |=> frame_err)
      else $error("bad parity write not flagged");
   a_err_one_cycle: assert property (
      @(posedge mclk) disable iff (!rst_b)
      frame_err |=> !frame_err)
      else $error("parity error pulse longer than one cycle");

   // a written one clears the flag unless a new event arrives
   a_overall_clear: assert property (
      @(posedge mclk) disable iff (!rst_b)
      s_main_write ##0 (main_clr[selftest_pkg::BIT_OVERALL] &&
                        !selftest_overall_fail)
      |=> !result_main[selftest_pkg::BIT_OVERALL])
      else $error("overall flag not cleared by write");
   a_thermal_clear: assert property (
      @(posedge mclk) disable iff (!rst_b)
      s_main_write ##0 (main_clr[selftest_pkg::BIT_THERMAL] &&
                        !thermal_trip_check_fail)
      |=> !result_main[selftest_pkg::BIT_THERMAL])
      else $error("thermal flag not cleared by write");

   // answer frame contents and frame bit counting
   a_answer_parity: assert property (
      @(posedge mclk) disable iff (!rst_b)
      s_frame_start |=> (^st_ff.shift_out) == 1'b1)
      else $error("answer frame parity wrong");
   a_sensor_upper_zero: assert property (
      @(posedge mclk) disable iff (!rst_b)
      s_frame_start ##0 s_last_was_sensor
      |=> st_ff.shift_out[8:5] == 4'h0)
      else $error("sensor answer upper bits not zero");
   a_other_reads_zero: assert property (
      @(posedge mclk) disable iff (!rst_b)
      s_frame_start ##0 s_last_was_other
      |=> st_ff.shift_out[8:1] == 8'h00)
      else $error("unknown address answer not zero");
   a_count_capped: assert property (
      @(posedge mclk) disable iff (!rst_b)
      st_ff.bit_cnt <= (selftest_pkg::BIT_CNT_LAST + 5'h01))
      else $error("frame bit counter ran past sixteen");

endmodule // selftest_result_flags

// ### src/selftest_pkg.sv
// constants and frame layout for the self-test result flag block
//****************************************************************
// Function
// - main register bit 7: overall self-test failed
// - main register bit 6: thermal trip check failed
// - main register bit 5: pre-regulator overvoltage check
// - main register bit 4: pre-regulator undervoltage check
// - bits 3,2: controller rail over/undervoltage checks
// - main register bit 1: general rail overvoltage
// - main register bit 0: general rail undervoltage
// - sensor register bit 3 sensor one overvoltage
// - sensor register bit 2: sensor one undervoltage
// - sensor register bit 1: sensor two overvoltage
// - sensor register bit 0: sensor two undervoltage
//****************************************************************
package selftest_pkg;
   // register addresses
   localparam logic [4:0] ADDR_RESULT_MAIN   = 5'h0d;
   localparam logic [4:0] ADDR_RESULT_SENSOR = 5'h0e;
   // reset values
   localparam logic [7:0] RESULT_MAIN_RST    = 8'h00;
   localparam logic [3:0] RESULT_SENSOR_RST  = 4'h0;
   // frame field positions (msb first on the wire)
   localparam int FRAME_LEN     = 16;
   localparam int ADDR_MSB      = 15;
   localparam int ADDR_LSB      = 11;
   localparam int TYPE_POS      = 10;
   localparam int DATA_MSB      = 8;
   localparam int DATA_LSB      = 1;
   localparam int PARITY_POS    = 0;
   localparam logic [4:0] BIT_CNT_LAST = 5'h0f;
   // main register bit positions
   localparam int BIT_OVERALL   = 7;
   localparam int BIT_THERMAL   = 6;
   localparam int BIT_PREREG_OV = 5;
   localparam int BIT_PREREG_UV = 4;
   localparam int BIT_MCU_OV    = 3;
   localparam int BIT_MCU_UV    = 2;
   localparam int BIT_GEN_OV    = 1;
   localparam int BIT_GEN_UV    = 0;
endpackage

// ### tb/serial_host_model.sv
// host side model that runs 16-bit serial frames into the flag block
`timescale 1ns/1ps
module serial_host_model (
   // pacing clock
   input  wire logic        mclk,
   // serial pins
   output logic             sclk,
   output logic             cs_b,
   output logic             mosi,
   input  wire logic        miso,
   input  wire logic        miso_oe_b,
   // answer word captured during the last frame
   output logic             rsp_stb,
   output logic [15:0]      rsp_word
);
   // idle: clock low, not selected
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      mosi = 1'b0;
      rsp_stb = 1'b0;
      rsp_word = 16'h0000;
   end
   // one frame msb first; half period of 5 mclk keeps above the 3 mclk floor
   task automatic xfer(input logic [15:0] frame);
      logic [15:0] rx;
      rx = 16'h0000;
      cs_b = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi = frame[i];
         repeat (5) @(posedge mclk);
         #1 sclk = 1'b1;
         // a released line reads as the inverse of its last level
         rx[i] = miso_oe_b ? ~miso : miso;
         repeat (5) @(posedge mclk);
         #1 sclk = 1'b0;
      end
      repeat (5) @(posedge mclk);
      #1 cs_b = 1'b1;
      mosi = ~mosi; // released line shows no stale bit
      rsp_word = rx;
      rsp_stb = 1'b1;
      @(posedge mclk);
      #1 rsp_stb = 1'b0;
      // deselect gap well over 4 mclk
      repeat (6) @(posedge mclk);
      #1;
   endtask
endmodule // serial_host_model

// ### tb/selftest_result_flags_tb_top.sv
// self-checking bench for the self-test result flag block
`timescale 1ns/1ps
module selftest_result_flags_tb_top;
   localparam logic [4:0] A_M = selftest_pkg::ADDR_RESULT_MAIN;
   localparam logic [4:0] A_S = selftest_pkg::ADDR_RESULT_SENSOR;
   logic        mclk, rst_b, sclk, cs_b, mosi, miso, miso_oe_b, frame_err;
   logic        rsp_stb;
   logic [11:0] ev;       // event pulses: [7:0] main, [11:8] sensor
   logic [7:0]  result_main, exp_main;
   logic [3:0]  result_sensor, exp_sens;
   logic [15:0] rsp_word;
   logic [4:0]  prev_addr, adr_tab[4];
   logic [16:0] note_q[$], note;   // {checked, expected answer}
   logic [31:0] rng;
   int          n_errors, checked, n_ferr, cyc;
   // 200 MHz clock
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   serial_host_model host (.mclk(mclk), .sclk(sclk), .cs_b(cs_b),
      .mosi(mosi), .miso(miso), .miso_oe_b(miso_oe_b),
      .rsp_stb(rsp_stb), .rsp_word(rsp_word));
   selftest_result_flags uut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk),
      .cs_b(cs_b), .mosi(mosi), .miso(miso), .miso_oe_b(miso_oe_b),
      .selftest_overall_fail(ev[7]), .thermal_trip_check_fail(ev[6]),
      .prereg_overvolt_check_fail(ev[5]),
      .prereg_undervolt_check_fail(ev[4]),
      .mcu_rail_overvolt_check_fail(ev[3]),
      .mcu_rail_undervolt_check_fail(ev[2]),
      .general_rail_overvolt_check_fail(ev[1]),
      .general_rail_undervolt_check_fail(ev[0]),
      .sensor_one_overvolt_check_fail(ev[11]),
      .sensor_one_undervolt_check_fail(ev[10]),
      .sensor_two_overvolt_check_fail(ev[9]),
      .sensor_two_undervolt_check_fail(ev[8]),
      .result_main(result_main), .result_sensor(result_sensor),
      .frame_err(frame_err));
   //*********************************************************************
   // helpers
   //*********************************************************************
   // xorshift stream
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // frame with odd parity over bits 15..1, or a broken one
   function automatic logic [15:0] mk(input logic [4:0] a, input logic w,
                                      input logic [7:0] d, input logic ok);
      logic [14:0] u;
      u = {a, w, 1'b0, d};
      return {u, ~^u ^ ~ok};
   endfunction
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t answer %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flags(input logic [11:0] exp);
      checked++;
      if ({result_sensor, result_main} !== exp) begin
         n_errors++;
         $display("[ERR] %0t flags %h expected %h", $time,
                  {result_sensor, result_main}, exp);
      end
   endtask
   // raise events for one cycle, flags follow on that edge
   task automatic pulse(input logic [11:0] v);
      ev = v;
      @(posedge mclk);
      #1 ev = 12'h000;
      exp_main |= v[7:0];
      exp_sens |= v[11:8];
      cmp_flags({exp_sens, exp_main});
   endtask
   // one frame; answer expected is the previous address and its contents
   task automatic access(input logic [4:0] a, input logic w,
                         input logic [7:0] d, input logic ok);
      logic [7:0] rd;
      rd = (prev_addr == A_M) ? exp_main :
           (prev_addr == A_S) ? {4'h0, exp_sens} : 8'h00;
      // every answer is checked, also the one after a refused frame
      note_q.push_back({1'b1, mk(prev_addr, 1'b0, rd, 1'b1)});
      host.xfer(mk(a, w, d, ok));
      if (ok && w && a == A_M) exp_main &= ~d;
      if (ok && w && a == A_S) exp_sens &= ~d[3:0];
      prev_addr = a;
      cmp_flags({exp_sens, exp_main});
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // parity error pulses, counted mid-cycle where they have settled
   always @(negedge mclk) begin
      if (frame_err === 1'b1) n_ferr++;
   end
   // answer monitor and hang guard
   always @(posedge mclk) begin
      cyc++;
      if (rsp_stb === 1'b1) begin
         note = note_q.pop_front();
         if (note[16]) cmp_word(rsp_word, note[15:0]);
      end
      if (cyc == 60000) begin
         n_errors++;
         $display("[ERR] %0t run did not finish", $time);
         report_and_stop();
      end
   end
   //*********************************************************************
   // main sequence
   //*********************************************************************
   initial begin
      rst_b = 1'b0;
      ev = 12'h000;
      rng = 32'hcc77a369;
      {exp_main, exp_sens, prev_addr} = '0;
      adr_tab = '{A_M, A_S, 5'h0f, A_M};
      repeat (12) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge mclk);
      #1 cmp_flags(12'h000);
      cmp_word({15'h0, miso_oe_b}, 16'h0001);
      access(A_M, 1'b0, 8'h00, 1'b1);
      access(A_S, 1'b0, 8'h00, 1'b1);
      $display("test reset values done");
      // each flag alone: set, read both registers, clear it
      for (int i = 0; i < 12; i++) begin
         pulse(12'h001 << i);
         access(A_M, 1'b0, 8'h00, 1'b1);
         access(A_S, 1'b0, 8'h00, 1'b1);
         access(i < 8 ? A_M : A_S, 1'b1, 8'h01 << (i % 8), 1'b1);
      end
      $display("test single flags done");
      // bad parity writes clear nothing; reserved place reads zero
      pulse(12'hfff);
      access(A_M, 1'b1, 8'hff, 1'b0);
      access(A_S, 1'b1, 8'hff, 1'b0);
      cmp_word(16'(n_ferr), 16'h0002);
      access(A_M, 1'b0, 8'h00, 1'b1);
      access(5'h0f, 1'b0, 8'h00, 1'b1);
      access(A_S, 1'b1, 8'hff, 1'b1);
      access(A_S, 1'b0, 8'h00, 1'b1);
      $display("test refused frames done");
      // random events and clears over the two result registers and address 0f
      repeat (40) begin
         rng = xs(rng);
         pulse(rng[11:0]);
         rng = xs(rng);
         access(adr_tab[rng[17:16]], rng[18], rng[31:24], 1'b1);
      end
      access(A_M, 1'b0, 8'h00, 1'b1);
      cmp_word(16'(n_ferr), 16'h0002);
      $display("test random traffic done");
      report_and_stop();
   end
endmodule // selftest_result_flags_tb_top
